// [rtl/snafd_pkg.sv]
// package for the non-audio and stream format detector
// assumes a decoded subframe stream from the receiver front end
package snafd_pkg;
  localparam logic [7:0]  OFS_FMT_STATUS = 8'h08;
  localparam logic [7:0]  OFS_PREAMBLE_0 = 8'h09;
  localparam logic [7:0]  OFS_PREAMBLE_1 = 8'h0A;
  localparam logic [7:0]  OFS_PREAMBLE_2 = 8'h0B;
  localparam logic [7:0]  OFS_PREAMBLE_3 = 8'h0C;
  localparam logic [15:0] SYNC_WORD_A    = 16'hF872;
  localparam logic [15:0] SYNC_WORD_B    = 16'h4E1F;
  localparam logic [15:0] CD_SYNC_WORD   = 16'h1FFF;
  localparam logic [15:0] LD_SYNC_WORD   = 16'h7FFE;
  localparam int          TIMEOUT_FRAMES = 4096;
  localparam int          SILENCE_FRAMES = 1024;
  localparam int          CS_AUDIO_BIT   = 1;
  localparam int          FMT_PCM_BIT    = 0;
  localparam int          FMT_BURST_BIT  = 1;
  localparam int          FMT_LD_BIT     = 2;
  localparam int          FMT_CD_BIT     = 3;
  localparam int          FMT_SILENT_BIT = 4;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;

  typedef enum logic [2:0] {
    SNAFD_Z0 = 3'b000,
    SNAFD_Z1 = 3'b001,
    SNAFD_Z2 = 3'b011,
    SNAFD_Z3 = 3'b010,
    SNAFD_PA = 3'b110,
    SNAFD_PB = 3'b111,
    SNAFD_PC = 3'b101,
    SNAFD_PD = 3'b100
  } snafd_state_t;

  typedef struct packed {
    logic [15:0] word;
    logic        valid;
    logic        frame_end;
  } snafd_word_t;
endpackage : snafd_pkg

// [rtl/snafd_detect.sv]
// non-audio sync detector, format classifier and preamble capture
// assumes words arrive on clk from the decoder; register reads are
// combinational from an address port on the same clock
`timescale 1ns/10ps
`default_nettype none
module snafd_detect #(
  parameter int TIMEOUT  = snafd_pkg::TIMEOUT_FRAMES,
  parameter int SILENCE  = snafd_pkg::SILENCE_FRAMES
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire snafd_pkg::snafd_word_t in_word,
  input  wire logic [23:0]           in_sample,
  input  wire logic                  cs_a_bit1,
  input  wire logic                  cs_b_bit1,
  input  wire logic                  status_channel_select,
  input  wire logic                  preamble_edge,
  input  wire logic                  data_edge,
  input  wire logic [7:0]            rd_addr,
  output logic [7:0]                 rd_data,
  output logic [23:0]                out_sample,
  output logic                       out_valid,
  output logic                       audio_indicator,
  output logic                       nonaudio_detect_flag,
  output logic                       pll_update
);
  localparam int CW = $clog2(TIMEOUT + 1);
  localparam int SW = $clog2(SILENCE + 1);

  initial begin
    if (TIMEOUT < 2 || SILENCE < 2) begin
      $error("snafd_detect: counts too small");
    end
  end

  snafd_pkg::snafd_state_t state_reg, state_next;
  logic          flag_reg, flag_next;
  logic [CW-1:0] tmo_reg, tmo_next;
  logic [SW-1:0] sil_reg, sil_next;
  logic [15:0]   pc_reg, pc_next;
  logic [15:0]   pd_reg, pd_next;
  logic [4:0]    fmt_reg, fmt_next;
  logic [23:0]   samp_reg;
  logic          sval_reg;
  logic          match;

  always_comb begin
    state_next = state_reg;
    pc_next    = pc_reg;
    pd_next    = pd_reg;
    match      = 1'b0;
    if (in_word.valid) begin
      case (state_reg)
        // each zero word advances; anything else restarts
        snafd_pkg::SNAFD_Z0: state_next = (in_word.word == 16'h0000)
                              ? snafd_pkg::SNAFD_Z1 : snafd_pkg::SNAFD_Z0;
        snafd_pkg::SNAFD_Z1: state_next = (in_word.word == 16'h0000)
                              ? snafd_pkg::SNAFD_Z2 : snafd_pkg::SNAFD_Z0;
        snafd_pkg::SNAFD_Z2: state_next = (in_word.word == 16'h0000)
                              ? snafd_pkg::SNAFD_Z3 : snafd_pkg::SNAFD_Z0;
        snafd_pkg::SNAFD_Z3: state_next = (in_word.word == 16'h0000)
                              ? snafd_pkg::SNAFD_PA : snafd_pkg::SNAFD_Z0;
        // four zeros seen; extra zeros keep waiting for the first sync
        snafd_pkg::SNAFD_PA: begin
          if (in_word.word == snafd_pkg::SYNC_WORD_A) begin
            state_next = snafd_pkg::SNAFD_PB;
          end else if (in_word.word == 16'h0000) begin
            state_next = snafd_pkg::SNAFD_PA;
          end else begin
            state_next = snafd_pkg::SNAFD_Z0;
          end
        end
        snafd_pkg::SNAFD_PB: begin
          if (in_word.word == snafd_pkg::SYNC_WORD_B) begin
            match      = 1'b1;
            state_next = snafd_pkg::SNAFD_PC;
          end else begin
            state_next = snafd_pkg::SNAFD_Z0;
          end
        end
        snafd_pkg::SNAFD_PC: begin
          pc_next    = in_word.word;
          state_next = snafd_pkg::SNAFD_PD;
        end
        snafd_pkg::SNAFD_PD: begin
          pd_next    = in_word.word;
          state_next = snafd_pkg::SNAFD_Z0;
        end
        default: state_next = snafd_pkg::SNAFD_Z0;
      endcase
    end
  end

  // flag and frame timeout; a match in the timeout frame wins
  always_comb begin
    flag_next = flag_reg;
    tmo_next  = tmo_reg;
    if (match) begin
      flag_next = 1'b1;
      tmo_next  = '0;
    end else if (flag_reg && in_word.valid && in_word.frame_end) begin
      if (tmo_reg == CW'(TIMEOUT - 1)) begin
        flag_next = 1'b0;
        tmo_next  = '0;
      end else begin
        tmo_next = tmo_reg + CW'(1);
      end
    end
  end

  // classification: silence after a run of zero frames, else by sync
  always_comb begin
    sil_next = sil_reg;
    fmt_next = fmt_reg;
    if (in_word.valid) begin
      if (in_word.word != 16'h0000) begin
        sil_next = '0;
      end else if (in_word.frame_end && sil_reg != SW'(SILENCE)) begin
        sil_next = sil_reg + SW'(1);
      end
      fmt_next = '0;
      if (sil_next == SW'(SILENCE)) begin
        fmt_next[snafd_pkg::FMT_SILENT_BIT] = 1'b1;
      end else if (flag_next) begin
        fmt_next[snafd_pkg::FMT_BURST_BIT] = 1'b1;
      end else if (in_word.word == snafd_pkg::CD_SYNC_WORD) begin
        fmt_next[snafd_pkg::FMT_CD_BIT] = 1'b1;
      end else if (in_word.word == snafd_pkg::LD_SYNC_WORD) begin
        fmt_next[snafd_pkg::FMT_LD_BIT] = 1'b1;
      end else if (fmt_reg[snafd_pkg::FMT_CD_BIT] ||
                   fmt_reg[snafd_pkg::FMT_LD_BIT]) begin
        fmt_next = fmt_reg;
      end else begin
        fmt_next[snafd_pkg::FMT_PCM_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= snafd_pkg::SNAFD_Z0;
      flag_reg  <= 1'b0;
      tmo_reg   <= '0;
      sil_reg   <= '0;
      pc_reg    <= '0;
      pd_reg    <= '0;
      fmt_reg   <= '0;
      samp_reg  <= '0;
      sval_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      flag_reg  <= flag_next;
      tmo_reg   <= tmo_next;
      sil_reg   <= sil_next;
      pc_reg    <= pc_next;
      pd_reg    <= pd_next;
      fmt_reg   <= fmt_next;
      samp_reg  <= in_sample;
      sval_reg  <= in_word.valid;
    end
  end

  // register reads; unmapped offsets read as zero
  always_comb begin
    case (rd_addr)
      snafd_pkg::OFS_FMT_STATUS: rd_data = {3'b000, fmt_reg};
      snafd_pkg::OFS_PREAMBLE_0: rd_data = pc_reg[15:8];
      snafd_pkg::OFS_PREAMBLE_1: rd_data = pc_reg[7:0];
      snafd_pkg::OFS_PREAMBLE_2: rd_data = pd_reg[15:8];
      snafd_pkg::OFS_PREAMBLE_3: rd_data = pd_reg[7:0];
      default:                   rd_data = snafd_pkg::RESET_BYTE;
    endcase
  end

  // select chooses the block; flag ORs in regardless of channel
  assign audio_indicator = flag_reg |
    (status_channel_select ? cs_b_bit1 : cs_a_bit1);
  assign nonaudio_detect_flag = flag_reg;
  assign out_sample = samp_reg;
  assign out_valid  = sval_reg;
  // data transitions never feed the lock update
  assign pll_update = preamble_edge;

  match_sets_a: assert property (@(posedge clk) disable iff (rst)
    match |=> flag_reg) else $error("flag not set by sync");
  seq_restart_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg == snafd_pkg::SNAFD_PB && in_word.valid &&
     in_word.word != snafd_pkg::SYNC_WORD_B)
    |=> state_reg == snafd_pkg::SNAFD_Z0)
    else $error("search did not restart");
  timeout_clr_a: assert property (@(posedge clk) disable iff (rst)
    (flag_reg && !match && in_word.valid && in_word.frame_end &&
     tmo_reg == CW'(TIMEOUT - 1)) |=> !flag_reg)
    else $error("flag not cleared at timeout");
  flag_hold_a: assert property (@(posedge clk) disable iff (rst)
    (!flag_reg && !match) |=> !flag_reg)
    else $error("flag rose without sync");
  audio_or_a: assert property (@(posedge clk) disable iff (rst)
    audio_indicator == (flag_reg | (status_channel_select ?
      cs_b_bit1 : cs_a_bit1))) else $error("audio bit wrong");
  pass_thru_a: assert property (@(posedge clk) disable iff (rst)
    ##1 out_sample == $past(in_sample))
    else $error("sample altered");
  fmt_onehot_a: assert property (@(posedge clk) disable iff (rst)
    $onehot0(fmt_reg)) else $error("format not one-hot");
  pc_capture_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg == snafd_pkg::SNAFD_PC && in_word.valid)
    |=> pc_reg == $past(in_word.word))
    else $error("burst info not captured");
  pd_capture_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg == snafd_pkg::SNAFD_PD && in_word.valid)
    |=> pd_reg == $past(in_word.word))
    else $error("burst length not captured");
  short_run_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg == snafd_pkg::SNAFD_Z3 && in_word.valid &&
     in_word.word == snafd_pkg::SYNC_WORD_A) |=> !flag_reg || $past(flag_reg))
    else $error("sync taken after three zeros");
  pll_data_a: assert property (@(posedge clk) disable iff (rst)
    (data_edge && !preamble_edge) |-> !pll_update)
    else $error("data bit fed lock");
endmodule : snafd_detect
`default_nettype wire

// [verification/snafd_src.sv]
// s/pdif source model: decoded words, samples and decoder edge pulses
// assumes the bench calls send and idle from its main thread
`timescale 1ns/10ps
`default_nettype none
module snafd_src (
  input  wire logic              clk,
  output var snafd_pkg::snafd_word_t w,
  output var logic [23:0]        smp,
  output var logic               pre,
  output var logic               dat
);
  initial begin
    w = '0;
    smp = '0;
    pre = 1'b0;
    dat = 1'b0;
  end
  task send(input logic [15:0] v, input logic fe);
    @(negedge clk);
    w <= '{word: v, valid: 1'b1, frame_end: fe};
    smp <= {8'h00, v};
    // preamble pulse only at frame boundaries, data pulse otherwise
    pre <= fe;
    dat <= ~fe;
  endtask : send
  task idle();
    @(negedge clk);
    // released word and sample lines never keep the last value
    w <= '{word: ~w.word, valid: 1'b0, frame_end: 1'b0};
    smp <= ~smp;
    pre <= 1'b0;
    dat <= 1'b0;
  endtask : idle
endmodule : snafd_src
`default_nettype wire

// [verification/tb.sv]
// self-checking bench for the non-audio and format detector
// assumes TIMEOUT 8 and SILENCE 4, combinational register reads
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                   clk, rst, cs_a, cs_b, sel, pll, ind, flag, ov;
  logic [7:0]             rd_addr, rd_data;
  logic [23:0]            smp, osmp;
  logic                   pre, dat;
  snafd_pkg::snafd_word_t w;
  int                     fails, num_checks, cyc, i;
  logic [3:0]             rows [8] = '{4'h0, 4'h9, 4'h4, 4'hD,
                                       4'h2, 4'hA, 4'h7, 4'hF};
  snafd_src u_src (.clk(clk), .w(w), .smp(smp), .pre(pre), .dat(dat));
  snafd_detect #(.TIMEOUT(8), .SILENCE(4)) dut_u (
    .clk(clk), .rst(rst), .in_word(w), .in_sample(smp),
    .cs_a_bit1(cs_a), .cs_b_bit1(cs_b), .status_channel_select(sel),
    .preamble_edge(pre), .data_edge(dat), .rd_addr(rd_addr),
    .rd_data(rd_data), .out_sample(osmp), .out_valid(ov),
    .audio_indicator(ind), .nonaudio_detect_flag(flag), .pll_update(pll));
  task final_report();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task chk(input string n, input logic [23:0] e, input logic [23:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) rd_addr = a;
    #1 chk("rd_data", {16'h0, e}, {16'h0, rd_data});
  endtask : rd
  task tx(input logic [15:0] v, input logic fe);
    u_src.send(v, fe);
    @(posedge clk);
    #1 chk("out_sample", {8'h00, v}, osmp);
    chk("out_valid", 24'h1, {23'h0, ov});
    chk("pll_update", {23'h0, fe}, {23'h0, pll});
  endtask : tx
  task sync();
    for (i = 0; i < 4; i++) tx(16'h0000, 1'b0);
    tx(snafd_pkg::SYNC_WORD_A, 1'b0);
    tx(snafd_pkg::SYNC_WORD_B, 1'b0);
  endtask : sync
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    rst = 1'b1; cs_a = 1'b0; cs_b = 1'b0; sel = 1'b0; rd_addr = 8'h00;
    repeat (12) @(posedge clk);
    for (i = 8; i < 13; i++) rd(i[7:0], 8'h00);
    rd(8'h20, 8'h00);
    @(negedge clk) rst = 1'b0;
    chk("flag", 24'h0, {23'h0, flag});
    $display("test reset done");
    for (int r = 0; r < 8; r++) begin
      @(negedge clk) {cs_a, cs_b, sel} = rows[r][3:1];
      #1 chk("audio_indicator", {23'h0, rows[r][0]}, {23'h0, ind});
    end
    cs_a = 1'b0; cs_b = 1'b0; sel = 1'b0;
    $display("test channel select done");
    for (i = 0; i < 3; i++) tx(16'h0000, 1'b0);
    tx(16'hF872, 1'b0);
    tx(16'h4E1F, 1'b0);
    u_src.idle();
    repeat (2) @(posedge clk);
    #1 chk("flag short", 24'h0, {23'h0, flag});
    for (i = 0; i < 4; i++) tx(16'h0000, 1'b0);
    tx(16'hF872, 1'b0);
    tx(16'h1234, 1'b0);
    tx(16'h4E1F, 1'b0);
    u_src.idle();
    repeat (2) @(posedge clk);
    #1 chk("flag broken", 24'h0, {23'h0, flag});
    $display("test ordering done");
    tx(16'h0000, 1'b0);
    sync();
    tx(16'h1234, 1'b0);
    tx(16'hABCD, 1'b0);
    u_src.idle();
    #1 chk("flag", 24'h1, {23'h0, flag});
    chk("audio_indicator", 24'h1, {23'h0, ind});
    chk("out_sample unmuted", 24'h00ABCD, osmp);
    rd(8'h09, 8'h12);
    rd(8'h0A, 8'h34);
    rd(8'h0B, 8'hAB);
    rd(8'h0C, 8'hCD);
    rd(8'h08, 8'h02);
    $display("test burst done");
    for (i = 0; i < 7; i++) tx(16'h5555, 1'b1);
    #1 chk("flag held", 24'h1, {23'h0, flag});
    tx(16'h5555, 1'b1);
    u_src.idle();
    #1 chk("flag timeout", 24'h0, {23'h0, flag});
    chk("audio_indicator", 24'h0, {23'h0, ind});
    rd(8'h08, 8'h01);
    $display("test timeout done");
    for (i = 0; i < 4; i++) tx(16'h0000, 1'b1);
    u_src.idle();
    rd(8'h08, 8'h10);
    tx(snafd_pkg::LD_SYNC_WORD, 1'b0);
    u_src.idle();
    rd(8'h08, 8'h04);
    tx(snafd_pkg::CD_SYNC_WORD, 1'b0);
    u_src.idle();
    rd(8'h08, 8'h08);
    $display("test formats done");
    final_report();
  end
endmodule : tb
`default_nettype wire
